//--- acf_pkg.sv
// Package with constants and types for the ALU condition flag register
// Function
// - Flag register readable; direct writes land only for ops that set no flags
// - Flag-affecting write to flags: flags win, result dropped
// - File clear on flags leaves 000u u1uu
// - Subtract drives carry and nibble carry as not-borrow
// - Bits seven to five ignore writes, read zero
// - Negative flag bit four follows result MSB
// - Signed wrap flag bit three marks sign overflow
// - Zero flag bit two set when result zero
// - Carry bit zero set on carry out of MSB
`default_nettype none
package acf_pkg;
  localparam int unsigned ACF_CARRY_BIT  = 0;      // Carry / not-borrow
  localparam int unsigned ACF_NIBBLE_BIT = 1;      // Nibble carry / not-borrow
  localparam int unsigned ACF_ZERO_BIT   = 2;      // Zero result
  localparam int unsigned ACF_WRAP_BIT   = 3;      // Signed wrap
  localparam int unsigned ACF_NEG_BIT    = 4;      // Negative result
  localparam logic [7:0]  ACF_IMPL_MASK  = 8'h1f;  // Implemented bits
  localparam logic [4:0]  ACF_RESET_VAL  = 5'h00;  // Flags after reset

  // ALU operations driven by the execution datapath
  typedef enum logic [3:0] {
    ACF_OP_ADD   = 4'h0,  // a + b
    ACF_OP_ADDC  = 4'h1,  // a + b + carry
    ACF_OP_SUB   = 4'h2,  // a - b
    ACF_OP_SUBB  = 4'h3,  // a - b - not carry
    ACF_OP_AND   = 4'h4,  // Logic, zero and negative only
    ACF_OP_IOR   = 4'h5,
    ACF_OP_XOR   = 4'h6,
    ACF_OP_CLR   = 4'h7,  // File clear, zero only
    ACF_OP_MOVE  = 4'h8,  // Moves, bit ops, swap: no flags
    ACF_OP_INC   = 4'h9,  // a + 1
    ACF_OP_DEC   = 4'ha   // a - 1
  } acf_op_e;

  // One instruction step from the execution datapath
  typedef struct packed {
    logic       valid;     // Instruction executes this cycle
    acf_op_e    op;        // Operation
    logic [7:0] opa;       // File operand
    logic [7:0] opb;       // Accumulator or literal
    logic       wr_en;     // Result goes to a file register
    logic       dst_flags; // Destination is the flag register
  } acf_instr_s;
endpackage : acf_pkg
`default_nettype wire

//--- acf_alu_flags.sv
// ALU with condition flag register
`timescale 1ns/1ps
`default_nettype none
module acf_alu_flags
  import acf_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Instruction from datapath
  input  wire acf_instr_s instr,
  // Results
  output logic [7:0]      result,     // Combinational ALU result
  output logic            file_we,    // Write result to file
  output logic [7:0]      flags_rd    // Flag register read value
);
  // Flag storage and adder internals; the register holds only the five implemented bits,
  // so nothing has to be masked on the way in
  logic [4:0] flags_ff;      // Stored flags
  logic [4:0] nxt_flags;     // Next flags
  logic [8:0] sum;           // Nine-bit sum with carry
  logic [4:0] low;           // Low nibble sum
  logic [7:0] bop;           // Effective second operand
  logic       cin;           // Effective carry in
  logic       arith;         // Op updates C/DC/OV
  logic       upd_nz;        // Op updates N/Z
  logic       upd_z_only;    // File clear only sets zero

  // One adder serves add, subtract, increment and decrement, so the carry and wrap
  // logic below is shared and cannot drift apart between the four cases
  // Operand shaping: subtraction adds the complement, so carry means not-borrow
  always_comb begin
    bop   = instr.opb;
    cin   = 1'b0;
    arith = 1'b1;
    upd_nz = 1'b1;
    upd_z_only = 1'b0;
    case (instr.op)
      ACF_OP_ADD:  begin cin = 1'b0; end
      ACF_OP_ADDC: begin cin = flags_ff[ACF_CARRY_BIT]; end
      ACF_OP_SUB:  begin bop = ~instr.opb; cin = 1'b1; end
      ACF_OP_SUBB: begin bop = ~instr.opb; cin = flags_ff[ACF_CARRY_BIT]; end
      ACF_OP_INC:  begin bop = 8'h01; end
      ACF_OP_DEC:  begin bop = 8'hff; end
      ACF_OP_CLR:  begin arith = 1'b0; upd_nz = 1'b0; upd_z_only = 1'b1; end
      ACF_OP_MOVE: begin arith = 1'b0; upd_nz = 1'b0; end
      default:     begin arith = 1'b0; end
    endcase
  end

  // Adder and result mux
  always_comb begin
    sum = {1'b0, instr.opa} + {1'b0, bop} + {8'h00, cin};
    low = {1'b0, instr.opa[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
    case (instr.op)
      ACF_OP_AND:  result = instr.opa & instr.opb;
      ACF_OP_IOR:  result = instr.opa | instr.opb;
      ACF_OP_XOR:  result = instr.opa ^ instr.opb;
      ACF_OP_CLR:  result = 8'h00;
      ACF_OP_MOVE: result = instr.opb;
      default:     result = sum[7:0];
    endcase
  end

  // Write to flags register is dropped when the op itself sets flags
  always_comb begin
    file_we = instr.valid & instr.wr_en & ~(instr.dst_flags & (arith | upd_nz | upd_z_only));
  end

  // Flag next-state
  // A direct write only lands for ops that touch no flag; otherwise the op's own
  // flag update wins and the computed result is thrown away for this register.
  // Flags an op does not name keep their stored value, which is what a clear relies on
  always_comb begin
    nxt_flags = flags_ff;
    if (instr.valid) begin
      if (instr.wr_en && instr.dst_flags && !(arith || upd_nz || upd_z_only)) begin
        nxt_flags = result[4:0];
      end
      if (upd_z_only) begin
        nxt_flags[ACF_ZERO_BIT] = 1'b1;
      end
      if (upd_nz) begin
        nxt_flags[ACF_NEG_BIT]  = result[7];
        nxt_flags[ACF_ZERO_BIT] = (result == 8'h00);
      end
      if (arith) begin
        nxt_flags[ACF_CARRY_BIT]  = sum[8];
        nxt_flags[ACF_NIBBLE_BIT] = low[4];
        nxt_flags[ACF_WRAP_BIT]   = (instr.opa[7] == bop[7]) && (sum[7] != instr.opa[7]);
      end
    end
  end

  // Flag register
  // Reset clears all five flags; software should not rely on any
  // particular value before its first flag-affecting instruction
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags_ff <= ACF_RESET_VAL;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Read: upper three bits are zero
  always_comb begin
    flags_rd = {3'h0, flags_ff} & ACF_IMPL_MASK;
  end

  // Checks
  // Every flag check on a taken instruction looks one edge after it and rebuilds the
  // expected value from the operands or the stored flags, never from the adder, so a broken adder trips them
  // Qualified instruction: reset masks out anything the datapath shows meanwhile
  logic arith_ok;
  assign arith_ok = instr.valid && !sys_rst;
  clear_sets_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (instr.valid && instr.op == ACF_OP_CLR) |=> flags_ff[ACF_ZERO_BIT] &&
      flags_ff[ACF_NEG_BIT] == $past(flags_ff[ACF_NEG_BIT]))
    else $error("clear did not leave zero set, others unchanged");
  flag_dst_drop_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (instr.valid && instr.dst_flags && instr.op == ACF_OP_ADD) |-> !file_we)
    else $error("result written over flags");
  upper_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    flags_rd[7:5] == 3'h0) else $error("upper bits not zero");
  neg_tracks_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (arith_ok && instr.op == ACF_OP_XOR) |=> flags_ff[ACF_NEG_BIT] == $past(instr.opa[7] ^ instr.opb[7]))
    else $error("negative flag wrong");
  zero_tracks_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (arith_ok && instr.op == ACF_OP_AND) |=> flags_ff[ACF_ZERO_BIT] == ($past(instr.opa & instr.opb) == 8'h00))
    else $error("zero flag wrong");
  carry_add_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (arith_ok && instr.op == ACF_OP_ADD) |=>
      flags_ff[ACF_CARRY_BIT] == ($past({1'b0, instr.opa}) + $past({1'b0, instr.opb}) > 9'h0ff))
    else $error("carry flag wrong");
  borrow_sub_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (arith_ok && instr.op == ACF_OP_SUB) |=> flags_ff[ACF_CARRY_BIT] == ($past(instr.opa) >= $past(instr.opb)))
    else $error("borrow sense wrong");
  nibble_add_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (arith_ok && instr.op == ACF_OP_ADD) |=>
      flags_ff[ACF_NIBBLE_BIT] == ($past({1'b0, instr.opa[3:0]}) + $past({1'b0, instr.opb[3:0]}) > 5'h0f))
    else $error("nibble carry wrong");
  wrap_add_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (arith_ok && instr.op == ACF_OP_ADD && instr.opa == 8'h7f && instr.opb == 8'h01) |=> flags_ff[ACF_WRAP_BIT])
    else $error("signed wrap missed");
  move_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (instr.valid && instr.op == ACF_OP_MOVE && instr.wr_en && instr.dst_flags) |=> flags_ff == $past(instr.opb[4:0]))
    else $error("move to flags lost");

  // Named steps for the checks below; each is one taken instruction, judged in the
  // same cycle for the file write check and at the following edge for the flag checks
  // A flag-affecting op aimed at the flag register with its write enable up
  sequence dst_flag_op_seq;
    instr.valid && instr.wr_en && instr.dst_flags && (instr.op != ACF_OP_MOVE);
  endsequence

  // A file clear taken this cycle, whatever its destination
  sequence clr_taken_seq;
    instr.valid && instr.op == ACF_OP_CLR;
  endsequence

  // A plain subtract taken outside reset
  sequence sub_taken_seq;
    arith_ok && instr.op == ACF_OP_SUB;
  endsequence

  // A subtract with borrow taken outside reset
  sequence subb_taken_seq;
    arith_ok && instr.op == ACF_OP_SUBB;
  endsequence

  // Every flag-affecting op, not only add, keeps its result off the flag register
  flag_op_nowrite_a: assert property (@(posedge mclk) disable iff (sys_rst)
    dst_flag_op_seq |-> !file_we)
    else $error("flag-affecting result written over flags");

  // Flags follow the op, not the result bits: 01 plus 01 gives 02, whose
  // bit one would wrongly set nibble carry if the result were stored
  dst_add_flags_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (instr.valid && instr.wr_en && instr.dst_flags && instr.op == ACF_OP_ADD &&
      instr.opa == 8'h01 && instr.opb == 8'h01) |=> flags_ff == 5'h00)
    else $error("flags taken from result instead of op");

  // File clear leaves signed wrap, nibble carry and carry as they were
  clear_keep_rest_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clr_taken_seq |=> flags_ff[ACF_WRAP_BIT] == $past(flags_ff[ACF_WRAP_BIT]) &&
      flags_ff[ACF_NIBBLE_BIT] == $past(flags_ff[ACF_NIBBLE_BIT]) &&
      flags_ff[ACF_CARRY_BIT] == $past(flags_ff[ACF_CARRY_BIT]))
    else $error("clear disturbed wrap, nibble or carry flag");

  // Subtract: nibble carry reads as not digit-borrow
  nibble_borrow_a: assert property (@(posedge mclk) disable iff (sys_rst)
    sub_taken_seq |=> flags_ff[ACF_NIBBLE_BIT] == ($past(instr.opa[3:0]) >= $past(instr.opb[3:0])))
    else $error("nibble borrow sense wrong");

  // Subtract with borrow: a clear carry going in takes one more away
  borrow_subb_a: assert property (@(posedge mclk) disable iff (sys_rst)
    subb_taken_seq |=> flags_ff[ACF_CARRY_BIT] ==
      $past({1'b0, instr.opa} >= ({1'b0, instr.opb} + {8'h00, ~flags_ff[ACF_CARRY_BIT]})))
    else $error("borrow-in sense wrong");

  // Fixed corner cases rather than a formula, so these checks do not
  // simply repeat the sign-compare logic of the adder
  // Negative minus positive that lands positive is a signed wrap
  wrap_sub_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (arith_ok && instr.op == ACF_OP_SUB && instr.opa == 8'h80 && instr.opb == 8'h01) |=> flags_ff[ACF_WRAP_BIT])
    else $error("signed wrap on subtract missed");

  // Minus one plus one is zero, no signed wrap
  wrap_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (arith_ok && instr.op == ACF_OP_ADD && instr.opa == 8'hff && instr.opb == 8'h01) |=> !flags_ff[ACF_WRAP_BIT])
    else $error("signed wrap set without overflow");

  // Increment: carry only when the operand rolls over from ff
  carry_inc_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (arith_ok && instr.op == ACF_OP_INC) |=> flags_ff[ACF_CARRY_BIT] == ($past(instr.opa) == 8'hff))
    else $error("increment carry wrong");

  // Decrement adds ff, so carry stays set unless the operand was zero
  borrow_dec_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (arith_ok && instr.op == ACF_OP_DEC) |=> flags_ff[ACF_CARRY_BIT] == ($past(instr.opa) != 8'h00))
    else $error("decrement carry wrong");
endmodule : acf_alu_flags
`default_nettype wire

//--- acf_alu_flags_tb.sv
// Self-checking bench for the ALU condition flag register
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acf_pkg::*;
  logic       mclk;      // Core clock, 50 ns
  logic       sys_rst;   // Sync reset
  acf_instr_s instr;     // Instruction step
  logic [7:0] result;    // ALU result
  logic       file_we;   // File write strobe
  logic [7:0] flags_rd;  // Flag read value
  int         bad_count; // Mismatches
  int         cmp_count; // Comparisons

  acf_alu_flags u_dut (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .instr    (instr),
    .result   (result),
    .file_we  (file_we),
    .flags_rd (flags_rd)
  );

  // Free-running clock
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // Byte compare, four-state exact
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // One instruction: comb outputs mid-cycle, flags after the taking edge
  task automatic go(input acf_op_e op, input logic [7:0] a, input logic [7:0] b, input logic wr,
                    input logic dst, input logic [7:0] er, input logic ew, input logic [7:0] ef);
    @(posedge mclk);
    instr <= '{1'b1, op, a, b, wr, dst};
    @(negedge mclk);
    chk("result", er, result);
    chk("file_we", {7'h00, ew}, {7'h00, file_we});
    @(posedge mclk);
    instr.valid <= 1'b0;
    @(negedge mclk);
    chk("flags_rd", ef, flags_rd);
  endtask : go

  // Watchdog: the sequence needs about 40 cycles
  initial begin
    repeat (400) @(posedge mclk);
    bad_count++;
    complete_run();
  end

  // Main sequence; each line's flags follow from the flags left by the line before
  initial begin
    bad_count = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    instr = '{1'b0, ACF_OP_MOVE, 8'h00, 8'h00, 1'b0, 1'b0};
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chk("flags_rd", 8'h00, flags_rd);
    go(ACF_OP_ADD, 8'h7f, 8'h01, 1'b0, 1'b0, 8'h80, 1'b0, 8'h1a);
    go(ACF_OP_ADD, 8'hff, 8'h01, 1'b1, 1'b0, 8'h00, 1'b1, 8'h07);
    go(ACF_OP_ADDC, 8'h01, 8'h01, 1'b0, 1'b0, 8'h03, 1'b0, 8'h00);
    go(ACF_OP_SUB, 8'h05, 8'h03, 1'b0, 1'b0, 8'h02, 1'b0, 8'h03);
    go(ACF_OP_SUB, 8'h03, 8'h05, 1'b0, 1'b0, 8'hfe, 1'b0, 8'h10);
    go(ACF_OP_SUBB, 8'h05, 8'h03, 1'b0, 1'b0, 8'h01, 1'b0, 8'h03);
    go(ACF_OP_SUB, 8'h80, 8'h01, 1'b0, 1'b0, 8'h7f, 1'b0, 8'h09);
    go(ACF_OP_AND, 8'h0f, 8'hf0, 1'b0, 1'b0, 8'h00, 1'b0, 8'h0d);
    go(ACF_OP_IOR, 8'h80, 8'h01, 1'b0, 1'b0, 8'h81, 1'b0, 8'h19);
    go(ACF_OP_XOR, 8'h55, 8'h55, 1'b0, 1'b0, 8'h00, 1'b0, 8'h0d);
    go(ACF_OP_INC, 8'hff, 8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 8'h07);
    go(ACF_OP_DEC, 8'h00, 8'h00, 1'b0, 1'b0, 8'hff, 1'b0, 8'h10);
    go(ACF_OP_MOVE, 8'h00, 8'hfb, 1'b1, 1'b1, 8'hfb, 1'b1, 8'h1b);
    go(ACF_OP_CLR, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00, 1'b0, 8'h1f);
    go(ACF_OP_ADD, 8'h01, 8'h01, 1'b1, 1'b1, 8'h02, 1'b0, 8'h00);
    go(ACF_OP_MOVE, 8'h00, 8'he5, 1'b1, 1'b1, 8'he5, 1'b1, 8'h05);
    go(ACF_OP_MOVE, 8'h00, 8'h1f, 1'b1, 1'b0, 8'h1f, 1'b1, 8'h05);
    complete_run();
  end
endmodule : tb
`default_nettype wire
